// >>> design/pcg_clock_gates.sv
`timescale 1ns/1ps

// Summary of operation
// - four byte gate registers, indices 300c-300f
// - reset loads first a3, second 3c
// - reset loads third 36, fourth ad
// - gate bit 0 stops, 1 delivers clock
// - first register bit 7 gates timer b
// - first register bit 5 gates timer a
// - bit 1 modulo timer, bit 0 rtc
// - reserved bits read zero, read-only
// - second reg: bit5 debug, bit4 nonvolatile
// - second reg: bit3 irq priority, bit2 checksum
// - third reg: serial a/b, sync serial, two-wire
// - fourth reg: comparator, converter, irq, touch, keyboard
module pcg_clock_gates (
  input  wire logic                        pclk,                    // bus clock
  input  wire logic                        presetn,                 // async reset, low
  input  wire logic                        psel,                    // apb select
  input  wire logic                        penable,                 // apb access phase
  input  wire logic                        pwrite,                  // apb direction
  input  wire logic [pcg_pkg::ADDR_W-1:0]  paddr,                   // apb byte address
  input  wire logic [pcg_pkg::DATA_W-1:0]  pwdata,                  // apb write data
  input  wire logic [3:0]                  pstrb,                   // apb byte strobes
  output logic      [pcg_pkg::DATA_W-1:0]  prdata,                  // apb read data
  output logic                             pready,                  // apb ready
  output logic                             pslverr,                 // apb error
  output logic                             flex_timer_b_gate,       // clock enable
  output logic                             flex_timer_a_gate,       // clock enable
  output logic                             modulo_timer_gate,       // clock enable
  output logic                             rtc_gate,                // clock enable
  output logic                             debug_unit_gate,         // clock enable
  output logic                             nonvolatile_ctrl_gate,   // clock enable
  output logic                             irq_priority_ctrl_gate,  // clock enable
  output logic                             checksum_gate,           // clock enable
  output logic                             serial_port_b_gate,      // clock enable
  output logic                             serial_port_a_gate,      // clock enable
  output logic                             sync_serial_gate,        // clock enable
  output logic                             two_wire_gate,           // clock enable
  output logic                             comparator_gate,         // clock enable
  output logic                             converter_gate,          // clock enable
  output logic                             ext_irq_gate,            // clock enable
  output logic                             touch_sense_gate,        // clock enable
  output logic                             keyboard_int_gate        // clock enable
);

  typedef struct packed {
    logic [pcg_pkg::DATA_W-1:0] rdata;
    logic                       err;
  } pcg_bus_s;

  pcg_bus_s state;
  pcg_bus_s next_state;

  logic [pcg_pkg::NUM_REGS-1:0]                     hit;
  logic [pcg_pkg::NUM_REGS-1:0]                     wr_en;
  logic [pcg_pkg::NUM_REGS-1:0][pcg_pkg::REG_W-1:0] gates;
  logic [pcg_pkg::REG_W-1:0]                        sel_data;
  logic                                             setup;
  logic                                             access;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb begin
    hit = '0;
    unique case (paddr)
      pcg_pkg::TIMER_GATES_ADDR:  hit[pcg_pkg::TIMER_SLOT]  = 1'b1;
      pcg_pkg::SYSTEM_GATES_ADDR: hit[pcg_pkg::SYSTEM_SLOT] = 1'b1;
      pcg_pkg::SERIAL_GATES_ADDR: hit[pcg_pkg::SERIAL_SLOT] = 1'b1;
      pcg_pkg::ANALOG_GATES_ADDR: hit[pcg_pkg::ANALOG_SLOT] = 1'b1;
      default:                    hit = '0;
    endcase
  end

  assign setup  = psel & ~penable;
  assign access = psel & penable;

  // ----------------------------------------------------------------
  // gate registers
  // ----------------------------------------------------------------
  // only the low byte lane carries data, so pstrb[0] qualifies the write
  genvar g;
  generate
    for (g = 0; g < pcg_pkg::NUM_REGS; g++) begin : g_reg
      assign wr_en[g] = access & pwrite & pstrb[0] & hit[g];
      pcg_gate_reg #(
        .RESET_VAL (pcg_pkg::GATES_RESET[g]),
        .BIT_MASK  (pcg_pkg::GATES_MASK[g])
      ) u_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_en[g]),
        .wr_data (pwdata[pcg_pkg::REG_W-1:0]),
        .value   (gates[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // data captured in the setup cycle so prdata comes from a flop yet
  // the access phase still completes with no wait state
  always_comb begin
    sel_data = '0;
    for (int i = 0; i < pcg_pkg::NUM_REGS; i++) begin
      if (hit[i]) begin
        sel_data = gates[i];
      end
    end
  end

  always_comb begin
    next_state = state;
    if (setup) begin
      next_state.err   = ~(|hit);
      next_state.rdata = '0;
      if (!pwrite) begin
        next_state.rdata = {{(pcg_pkg::DATA_W - pcg_pkg::REG_W){1'b0}}, sel_data};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.rdata <= '0;
      state.err   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign prdata  = state.rdata;
  assign pready  = 1'b1;
  assign pslverr = access & state.err;

  // ----------------------------------------------------------------
  // clock enables, straight from the register flops, so no decode
  // glitch reaches a downstream clock gate
  // ----------------------------------------------------------------
  assign flex_timer_b_gate      = gates[pcg_pkg::TIMER_SLOT][pcg_pkg::FLEX_TIMER_B_BIT];
  assign flex_timer_a_gate      = gates[pcg_pkg::TIMER_SLOT][pcg_pkg::FLEX_TIMER_A_BIT];
  assign modulo_timer_gate      = gates[pcg_pkg::TIMER_SLOT][pcg_pkg::MODULO_TIMER_BIT];
  assign rtc_gate               = gates[pcg_pkg::TIMER_SLOT][pcg_pkg::RTC_BIT];
  assign debug_unit_gate        = gates[pcg_pkg::SYSTEM_SLOT][pcg_pkg::DEBUG_UNIT_BIT];
  assign nonvolatile_ctrl_gate  = gates[pcg_pkg::SYSTEM_SLOT][pcg_pkg::NONVOLATILE_BIT];
  assign irq_priority_ctrl_gate = gates[pcg_pkg::SYSTEM_SLOT][pcg_pkg::IRQ_PRIORITY_BIT];
  assign checksum_gate          = gates[pcg_pkg::SYSTEM_SLOT][pcg_pkg::CHECKSUM_BIT];
  assign serial_port_b_gate     = gates[pcg_pkg::SERIAL_SLOT][pcg_pkg::SERIAL_PORT_B_BIT];
  assign serial_port_a_gate     = gates[pcg_pkg::SERIAL_SLOT][pcg_pkg::SERIAL_PORT_A_BIT];
  assign sync_serial_gate       = gates[pcg_pkg::SERIAL_SLOT][pcg_pkg::SYNC_SERIAL_BIT];
  assign two_wire_gate          = gates[pcg_pkg::SERIAL_SLOT][pcg_pkg::TWO_WIRE_BIT];
  assign comparator_gate        = gates[pcg_pkg::ANALOG_SLOT][pcg_pkg::COMPARATOR_BIT];
  assign converter_gate         = gates[pcg_pkg::ANALOG_SLOT][pcg_pkg::CONVERTER_BIT];
  assign ext_irq_gate           = gates[pcg_pkg::ANALOG_SLOT][pcg_pkg::EXT_IRQ_BIT];
  assign touch_sense_gate       = gates[pcg_pkg::ANALOG_SLOT][pcg_pkg::TOUCH_SENSE_BIT];
  assign keyboard_int_gate      = gates[pcg_pkg::ANALOG_SLOT][pcg_pkg::KEYBOARD_INT_BIT];

endmodule

// >>> design/pcg_pkg.sv
package pcg_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 32;
  localparam int REG_W    = 8;
  localparam int NUM_REGS = 4;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] TIMER_GATES_IDX  = 16'h300c;
  localparam logic [ADDR_W-1:0] SYSTEM_GATES_IDX = 16'h300d;
  localparam logic [ADDR_W-1:0] SERIAL_GATES_IDX = 16'h300e;
  localparam logic [ADDR_W-1:0] ANALOG_GATES_IDX = 16'h300f;
  localparam logic [ADDR_W-1:0] TIMER_GATES_ADDR  = ADDR_W'(TIMER_GATES_IDX << 2);
  localparam logic [ADDR_W-1:0] SYSTEM_GATES_ADDR = ADDR_W'(SYSTEM_GATES_IDX << 2);
  localparam logic [ADDR_W-1:0] SERIAL_GATES_ADDR = ADDR_W'(SERIAL_GATES_IDX << 2);
  localparam logic [ADDR_W-1:0] ANALOG_GATES_ADDR = ADDR_W'(ANALOG_GATES_IDX << 2);

  // ----------------------------------------------------------------
  // reset values and implemented-bit masks, register 0 in the low byte
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] TIMER_GATES_RESET  = 8'ha3;
  localparam logic [REG_W-1:0] SYSTEM_GATES_RESET = 8'h3c;
  localparam logic [REG_W-1:0] SERIAL_GATES_RESET = 8'h36;
  localparam logic [REG_W-1:0] ANALOG_GATES_RESET = 8'had;
  localparam logic [REG_W-1:0] TIMER_GATES_MASK   = 8'ha3;
  localparam logic [REG_W-1:0] SYSTEM_GATES_MASK  = 8'h3c;
  localparam logic [REG_W-1:0] SERIAL_GATES_MASK  = 8'h36;
  localparam logic [REG_W-1:0] ANALOG_GATES_MASK  = 8'had;

  localparam logic [NUM_REGS-1:0][REG_W-1:0] GATES_RESET = {
    ANALOG_GATES_RESET, SERIAL_GATES_RESET, SYSTEM_GATES_RESET, TIMER_GATES_RESET};
  localparam logic [NUM_REGS-1:0][REG_W-1:0] GATES_MASK = {
    ANALOG_GATES_MASK, SERIAL_GATES_MASK, SYSTEM_GATES_MASK, TIMER_GATES_MASK};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLEX_TIMER_B_BIT   = 7;
  localparam int FLEX_TIMER_A_BIT   = 5;
  localparam int MODULO_TIMER_BIT   = 1;
  localparam int RTC_BIT            = 0;
  localparam int DEBUG_UNIT_BIT     = 5;
  localparam int NONVOLATILE_BIT    = 4;
  localparam int IRQ_PRIORITY_BIT   = 3;
  localparam int CHECKSUM_BIT       = 2;
  localparam int SERIAL_PORT_B_BIT  = 5;
  localparam int SERIAL_PORT_A_BIT  = 4;
  localparam int SYNC_SERIAL_BIT    = 2;
  localparam int TWO_WIRE_BIT       = 1;
  localparam int COMPARATOR_BIT     = 7;
  localparam int CONVERTER_BIT      = 5;
  localparam int EXT_IRQ_BIT        = 3;
  localparam int TOUCH_SENSE_BIT    = 2;
  localparam int KEYBOARD_INT_BIT   = 0;

  // ----------------------------------------------------------------
  // register slots
  // ----------------------------------------------------------------
  localparam int TIMER_SLOT  = 0;
  localparam int SYSTEM_SLOT = 1;
  localparam int SERIAL_SLOT = 2;
  localparam int ANALOG_SLOT = 3;

endpackage

// >>> design/pcg_gate_reg.sv
`timescale 1ns/1ps

module pcg_gate_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] BIT_MASK  = 8'hff
) (
  input  wire logic       pclk,      // bus clock
  input  wire logic       presetn,   // async reset, active low
  input  wire logic       wr_en,     // one-cycle write strobe
  input  wire logic [7:0] wr_data,   // byte to store
  output logic      [7:0] value      // stored gate bits
);

  typedef struct packed {
    logic [7:0] value;
  } pcg_gate_reg_s;

  pcg_gate_reg_s state;
  pcg_gate_reg_s next_state;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.value = wr_data & BIT_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.value <= RESET_VAL;
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;

endmodule

// >>> test/pcg_clock_gates_chk.sv
`timescale 1ns/1ps

module pcg_clock_gates_chk (
  input wire logic        pclk,               // bus clock
  input wire logic        presetn,            // reset, low
  input wire logic        psel,               // select
  input wire logic        penable,            // access phase
  input wire logic        pwrite,             // direction
  input wire logic [15:0] paddr,              // byte address
  input wire logic [31:0] pwdata,             // write data
  input wire logic [3:0]  pstrb,              // strobes
  input wire logic [31:0] prdata,             // read data
  input wire logic        pready,             // ready
  input wire logic        pslverr,            // error
  input wire logic        flex_timer_b_gate,  // gate
  input wire logic        flex_timer_a_gate,  // gate
  input wire logic        modulo_timer_gate,  // gate
  input wire logic        rtc_gate,           // gate
  input wire logic        debug_unit_gate,    // gate
  input wire logic        serial_port_a_gate, // gate
  input wire logic        keyboard_int_gate   // gate
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  logic hit;
  assign acc = psel & penable;
  assign wr = acc & pwrite & pstrb[0];
  assign hit = paddr inside {16'hc030, 16'hc034, 16'hc038, 16'hc03c};
  chk_ready_high: assert property (psel |-> pready)
    else $error("pready low during transfer");
  chk_err_flag: assert property (acc |-> pslverr == !hit)
    else $error("pslverr does not match address decode");
  chk_rdata_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_read_timer: assert property (acc && !pwrite && paddr == 16'hc030 |->
    prdata[7:0] == {flex_timer_b_gate, 1'b0, flex_timer_a_gate, 3'b0, modulo_timer_gate,
    rtc_gate})
    else $error("timer register read differs from gates");
  chk_wr_timer: assert property (wr && paddr == 16'hc030 |=>
    flex_timer_b_gate == $past(pwdata[7]) && modulo_timer_gate == $past(pwdata[1]))
    else $error("timer gates not loaded by write");
  chk_wr_system: assert property (wr && paddr == 16'hc034 |=>
    debug_unit_gate == $past(pwdata[5])) else $error("debug gate not loaded");
  chk_wr_serial: assert property (wr && paddr == 16'hc038 |=>
    serial_port_a_gate == $past(pwdata[4])) else $error("serial gate not loaded");
  chk_wr_analog: assert property (wr && paddr == 16'hc03c |=>
    keyboard_int_gate == $past(pwdata[0])) else $error("keyboard gate not loaded");
  chk_gate_hold: assert property (!wr |=> $stable({flex_timer_b_gate, flex_timer_a_gate,
    rtc_gate, debug_unit_gate, serial_port_a_gate, keyboard_int_gate}))
    else $error("gate changed without write");
endmodule

bind pcg_clock_gates pcg_clock_gates_chk u_pcg_clock_gates_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .flex_timer_b_gate,
  .flex_timer_a_gate, .modulo_timer_gate, .rtc_gate, .debug_unit_gate, .serial_port_a_gate,
  .keyboard_int_gate);

// >>> test/tb.sv
`timescale 1ns/1ps

module tb;
  localparam logic [7:0] RV [4] = '{8'ha3, 8'h3c, 8'h36, 8'had};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'h4ec4;
  logic [3:0]  pstrb = 0;
  logic [7:0]  m [4];
  logic        flex_timer_b_gate, flex_timer_a_gate, modulo_timer_gate, rtc_gate;
  logic        debug_unit_gate, nonvolatile_ctrl_gate, irq_priority_ctrl_gate, checksum_gate;
  logic        serial_port_b_gate, serial_port_a_gate, sync_serial_gate, two_wire_gate;
  logic        comparator_gate, converter_gate, ext_irq_gate, touch_sense_gate;
  logic        keyboard_int_gate;
  int          bad_count = 0, compares = 0;

  pcg_clock_gates u_pcg_clock_gates (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .flex_timer_b_gate, .flex_timer_a_gate,
    .modulo_timer_gate, .rtc_gate, .debug_unit_gate, .nonvolatile_ctrl_gate,
    .irq_priority_ctrl_gate, .checksum_gate, .serial_port_b_gate, .serial_port_a_gate,
    .sync_serial_gate, .two_wire_gate, .comparator_gate, .converter_gate, .ext_irq_gate,
    .touch_sense_gate, .keyboard_int_gate);

  always #10 pclk = ~pclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [16:0] exp_gates();
    return {m[0][7], m[0][5], m[0][1], m[0][0], m[1][5], m[1][4], m[1][3], m[1][2],
            m[2][5], m[2][4], m[2][2], m[2][1], m[3][7], m[3][5], m[3][3], m[3][2], m[3][0]};
  endfunction

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask

  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    m = RV;
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // slots 4 and 5 are an unmapped and an unaligned address
  task automatic access(input int i, input logic w, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] a;
    a = (i < 4) ? 16'hc030 + 16'(4 * i) : (i == 4 ? 16'hc040 : 16'hc031);
    xfer(w, a, d, s);
    chk("slverr", {31'h0, er}, {31'h0, i > 3});
    if (w && i < 4 && s[0])
      m[i] = d[7:0] & RV[i];
    if (!w)
      chk("rdata", rd, (i < 4) ? {24'h0, m[i]} : 32'h0);
    @(negedge pclk);
    chk("gates", {15'h0, u_gates()}, {15'h0, exp_gates()});
  endtask

  function automatic logic [16:0] u_gates();
    return {flex_timer_b_gate, flex_timer_a_gate, modulo_timer_gate, rtc_gate,
            debug_unit_gate, nonvolatile_ctrl_gate, irq_priority_ctrl_gate, checksum_gate,
            serial_port_b_gate, serial_port_a_gate, sync_serial_gate, two_wire_gate,
            comparator_gate, converter_gate, ext_irq_gate, touch_sense_gate, keyboard_int_gate};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst();
    for (int i = 0; i < 4; i++)
      access(i, 1'b0, 32'h0, 4'hf);
    for (int i = 0; i < 6; i++) begin
      access(i, 1'b1, 32'hffffffff, 4'h1);
      access(i, 1'b0, 32'h0, 4'h0);
      access(i, 1'b1, 32'h0, 4'h1);
      access(i, 1'b0, 32'h0, 4'h0);
    end
    access(0, 1'b1, 32'hff, 4'he);
    repeat (80) begin
      seed = xs(seed);
      access(int'(seed[10:8]) % 6, seed[3], xs(seed), seed[7:4]);
    end
    rst();
    for (int i = 0; i < 4; i++)
      access(i, 1'b0, 32'h0, 4'hf);
    print_verdict();
  end
endmodule
